/* File: core/rtcctl_ctrl.sv */
`timescale 1ns/10ps
// Functional notes
// - count clock is source divided by two-power code
// - mode: wide, half counter, calendar, reserved
// - prescaler-only writes never raise busy; mode writes do
// - enable reads back written value immediately
// - enable write sets busy until applied
// - enable zero disabled, one enabled
// - enable and soft reset writable while locked; enable writes lost during soft reset
// - writing zero to soft reset does nothing
// - soft reset restores all but debug, disabled
// - soft reset discards other fields of write
// - soft reset and busy held until done
// - soft reset reads one while in progress
// - clear on match: wide/calendar only, when disabled
// - clear on match resets counter on match
// - hour format in calendar only, when disabled
// - control is protected, guarded, synchronised
// - byte and halfword accesses supported
module rtcctl_ctrl import rtcctl_pkg::*; #(
    parameter int SYNC_LEN = SYNC_TICKS
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // register port
    input  wire logic [ADDR_W-1:0] busAddr,
    input  wire logic [DATA_W-1:0] busWdata,
    input  wire logic [1:0]        busByteEn,
    input  wire logic              busWrite,
    input  wire logic              busRead,
    output logic [DATA_W-1:0]      busRdata,
    // write guard and source clock
    input  wire logic              writeGuard,
    input  wire logic              srcTick,
    // counter side
    input  wire logic              matchHit,
    output logic                   countEnable,
    output logic                   countTick,
    output logic [1:0]             countMode,
    output logic                   clearOnMatch,
    output logic                   hour12Format,
    output logic                   counterClear,
    output logic                   debugRun
);
    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    logic [PRESC_W-1:0] presc_r,   presc_nxt;
    logic [1:0]         mode_r,    mode_nxt;
    logic               match_r,   match_nxt;
    logic               hour_r,    hour_nxt;
    logic               enable_r,  enable_nxt;
    logic               active_r,  active_nxt;
    logic               soft_reset_r,   soft_reset_nxt;
    logic               busy_r,    busy_nxt;
    logic               debug_r,   debug_nxt;
    logic [DATA_W-1:0]  rdata_nxt;
    logic               syncStart;
    logic               syncDone;
    logic               divTick;
    logic               divClr;
    logic               wrCtrl;
    logic               locked;
    logic [DATA_W-1:0]  ctrlView;
    logic [DATA_W-1:0]  laneData;
    logic               wrDebug;
    logic               rdCtrl;
    logic               rdStatus;
    logic               rdDebug;
    logic               countEnable_nxt;
    logic               countTick_nxt;
    logic [1:0]         countMode_nxt;
    logic               clearOnMatch_nxt;
    logic               hour12Format_nxt;
    logic               counterClear_nxt;
    logic               debugRun_nxt;

    // ----------------------------------------------------------
    // mode decoding
    // ----------------------------------------------------------
    // clear on match means nothing to the half counter
    function automatic logic clearAllowed(input logic [1:0] m);
        clearAllowed = (m == 2'(WIDE_COUNTER_MODE))
                    || (m == 2'(CALENDAR_MODE));
    endfunction

    // only the calendar keeps hours
    function automatic logic hourAllowed(input logic [1:0] m);
        hourAllowed = (m == 2'(CALENDAR_MODE));
    endfunction

    // ----------------------------------------------------------
    // address decoding
    // ----------------------------------------------------------
    // reads need no guard: the guard protects writes only
    always_comb begin
        wrDebug  = busWrite && !writeGuard && busByteEn[0]
                && (busAddr == DEBUG_ADDR);
        rdCtrl   = 1'b0;
        rdStatus = 1'b0;
        rdDebug  = 1'b0;
        if (busAddr == CONTROL_ADDR) begin
            rdCtrl = busRead;
        end else if (busAddr == STATUS_ADDR) begin
            rdStatus = busRead;
        end else if (busAddr == DEBUG_ADDR) begin
            rdDebug = busRead;
        end
    end

    // ----------------------------------------------------------
    // register write and synchronisation
    // ----------------------------------------------------------
    always_comb begin
        presc_nxt  = presc_r;
        mode_nxt   = mode_r;
        match_nxt  = match_r;
        hour_nxt   = hour_r;
        enable_nxt = enable_r;
        active_nxt = active_r;
        soft_reset_nxt  = soft_reset_r;
        busy_nxt   = busy_r;
        debug_nxt  = debug_r;
        syncStart  = 1'b0;
        // guarded writes are dropped silently
        wrCtrl = busWrite && !writeGuard
              && (busAddr == CONTROL_ADDR);
        // the enable bit covers both enabled and being enabled
        locked = enable_r || active_r;
        // a finished crossing commits what was pending, soft reset first
        if (syncDone) begin
            if (soft_reset_r) begin
                presc_nxt  = CONTROL_RESET[PRESC_LSB +: PRESC_W];
                mode_nxt   = CONTROL_RESET[MODE_LSB +: 2];
                match_nxt  = CONTROL_RESET[CLEAR_MATCH_BIT];
                hour_nxt   = CONTROL_RESET[HOUR_FMT_BIT];
                enable_nxt = CONTROL_RESET[ENABLE_BIT];
                active_nxt = 1'b0;
                soft_reset_nxt  = 1'b0;
            end else begin
                active_nxt = enable_r;
            end
            busy_nxt = 1'b0;
        end
        if (wrCtrl && busByteEn[0]
            && busWdata[SOFT_RESET_BIT]) begin
            // nothing else in this write survives
            soft_reset_nxt  = 1'b1;
            busy_nxt   = 1'b1;
            enable_nxt = 1'b0;
            syncStart  = 1'b1;
        end else if (wrCtrl && !soft_reset_r) begin
            // writes during a pending soft reset are lost: poll busy
            if (busByteEn[0]) begin
                enable_nxt = busWdata[ENABLE_BIT];
                busy_nxt   = 1'b1;
                syncStart  = 1'b1;
                if (!locked) begin
                    mode_nxt  = busWdata[MODE_LSB +: 2];
                    match_nxt = busWdata[CLEAR_MATCH_BIT];
                    hour_nxt  = busWdata[HOUR_FMT_BIT];
                end
            end
            if (busByteEn[1] && !locked) begin
                presc_nxt = busWdata[PRESC_LSB +: PRESC_W];
            end
        end
        // debug control is outside the soft reset
        if (wrDebug) begin
            debug_nxt = busWdata[DEBUG_RUN_BIT];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            presc_r  <= CONTROL_RESET[PRESC_LSB +: PRESC_W];
            mode_r   <= CONTROL_RESET[MODE_LSB +: 2];
            match_r  <= 1'b0;
            hour_r   <= 1'b0;
            enable_r <= 1'b0;
            active_r <= 1'b0;
            soft_reset_r  <= 1'b0;
            busy_r   <= 1'b0;
            debug_r  <= 1'b0;
        end else begin
            presc_r  <= presc_nxt;
            mode_r   <= mode_nxt;
            match_r  <= match_nxt;
            hour_r   <= hour_nxt;
            enable_r <= enable_nxt;
            active_r <= active_nxt;
            soft_reset_r  <= soft_reset_nxt;
            busy_r   <= busy_nxt;
            debug_r  <= debug_nxt;
        end
    end

    // ----------------------------------------------------------
    // read port
    // ----------------------------------------------------------
    always_comb begin
        ctrlView = READ_ZERO;
        ctrlView[PRESC_LSB +: PRESC_W] = presc_r;
        ctrlView[CLEAR_MATCH_BIT]      = match_r;
        ctrlView[HOUR_FMT_BIT]         = hour_r;
        ctrlView[MODE_LSB +: 2]        = mode_r;
        ctrlView[ENABLE_BIT]           = enable_r;
        ctrlView[SOFT_RESET_BIT]       = soft_reset_r;
        rdata_nxt = READ_ZERO;
        // status holds only the pending flag, all else reads zero
        if (rdCtrl) begin
            rdata_nxt = ctrlView;
        end else if (rdStatus) begin
            rdata_nxt[SYNC_PEND_BIT] = busy_r;
        end else if (rdDebug) begin
            rdata_nxt[DEBUG_RUN_BIT] = debug_r;
        end
    end

    // ----------------------------------------------------------
    // byte lanes
    // ----------------------------------------------------------
    // a byte read never shows the neighbouring field, so software
    // may read either half on its own
    generate
        for (genvar lane = 0; lane < DATA_W / 8; lane++) begin : gLane
            assign laneData[lane*8 +: 8] = busByteEn[lane]
                                         ? rdata_nxt[lane*8 +: 8]
                                         : 8'h00;
        end
    endgenerate

    // ----------------------------------------------------------
    // counter side outputs
    // ----------------------------------------------------------
    // the divider restarts on every enable, so the first count tick
    // comes one full period after the enable has taken effect
    assign divClr = soft_reset_r || !active_r;

    always_comb begin
        countEnable_nxt  = active_r;
        countTick_nxt    = divTick && active_r;
        countMode_nxt    = mode_r;
        clearOnMatch_nxt = match_r && clearAllowed(mode_r);
        hour12Format_nxt = hour_r && hourAllowed(mode_r);
        // judged on the applied state, so no clear lands mid-switch
        counterClear_nxt = matchHit && countEnable && clearOnMatch;
        debugRun_nxt     = debug_r;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busRdata     <= READ_ZERO;
            countEnable  <= 1'b0;
            countTick    <= 1'b0;
            countMode    <= 2'(WIDE_COUNTER_MODE);
            clearOnMatch <= 1'b0;
            hour12Format <= 1'b0;
            counterClear <= 1'b0;
            debugRun     <= 1'b0;
        end else begin
            busRdata     <= laneData;
            countEnable  <= countEnable_nxt;
            countTick    <= countTick_nxt;
            countMode    <= countMode_nxt;
            clearOnMatch <= clearOnMatch_nxt;
            hour12Format <= hour12Format_nxt;
            counterClear <= counterClear_nxt;
            debugRun     <= debugRun_nxt;
        end
    end

    // ----------------------------------------------------------
    // submodules
    // ----------------------------------------------------------
    // reserved codes are clamped inside the divider
    rtcctl_prescaler #(
        .DIV_WIDTH (DIV_W)
    ) uPresc (
        .mclk    (mclk),
        .rst     (rst),
        .clr     (divClr),
        .code    (presc_r),
        .srcTick (srcTick),
        .divTick (divTick)
    );

    // the crossing is only modelled here; a real count domain needs
    // a toggle handshake in place of this tick counter
    rtcctl_sync_delay #(
        .TICKS (SYNC_LEN)
    ) uSync (
        .mclk    (mclk),
        .rst     (rst),
        .start   (syncStart),
        .srcTick (srcTick),
        .done    (syncDone)
    );
endmodule // rtcctl_ctrl

/* File: common/rtcctl_pkg.sv */
// ----------------------------------------------------------------
// constants of the counter control block
// ----------------------------------------------------------------
package rtcctl_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 16;
    localparam int          PRESC_W        = 4;
    localparam int          DIV_W          = 10;

    // register byte addresses
    localparam logic [7:0]  CONTROL_ADDR   = 8'h00;
    localparam logic [7:0]  STATUS_ADDR    = 8'h0A;
    localparam logic [7:0]  DEBUG_ADDR     = 8'h0E;

    // control, status and debug field positions
    localparam int          SOFT_RESET_BIT = 0;
    localparam int          ENABLE_BIT     = 1;
    localparam int          MODE_LSB       = 2;
    localparam int          HOUR_FMT_BIT   = 6;
    localparam int          CLEAR_MATCH_BIT = 7;
    localparam int          PRESC_LSB      = 8;
    localparam int          SYNC_PEND_BIT  = 7;
    localparam int          DEBUG_RUN_BIT  = 0;

    localparam logic [15:0] CONTROL_RESET  = 16'h0000;
    localparam logic [15:0] READ_ZERO      = 16'h0000;

    // prescaler codes
    localparam logic [3:0]  PRESC_MAX      = 4'hA;

    // synchronisation length, in source clock ticks
    localparam int          SYNC_TICKS     = 2;

    typedef enum logic [1:0] {
        WIDE_COUNTER_MODE,
        HALF_COUNTER_MODE,
        CALENDAR_MODE,
        RESERVED_MODE
    } rtcctl_mode_t;

    typedef enum logic [1:0] {
        SYNC_IDLE,
        SYNC_ENABLE,
        SYNC_RESET
    } rtcctl_sync_t;
endpackage

/* File: core/rtcctl_prescaler.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// power-of-two divider of the source clock ticks
// ----------------------------------------------------------------
module rtcctl_prescaler import rtcctl_pkg::*; #(
    parameter int DIV_WIDTH = DIV_W
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst,
    // control
    input  wire logic               clr,
    input  wire logic [PRESC_W-1:0] code,
    input  wire logic               srcTick,
    // result
    output logic                    divTick
);
    logic [DIV_WIDTH-1:0] cnt_r;
    logic [DIV_WIDTH-1:0] cnt_nxt;
    logic                 divTick_nxt;
    logic [DIV_WIDTH-1:0] last;
    logic [PRESC_W-1:0]   useCode;

    always_comb begin
        // reserved codes run at the slowest legal rate
        useCode     = (code > PRESC_MAX) ? PRESC_MAX : code;
        last        = DIV_WIDTH'((1 << useCode) - 1);
        cnt_nxt     = cnt_r;
        divTick_nxt = 1'b0;
        if (clr) begin
            cnt_nxt = '0;
        end else if (srcTick) begin
            if (cnt_r >= last) begin
                cnt_nxt     = '0;
                divTick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r  <= '0;
            divTick <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            divTick <= divTick_nxt;
        end
    end
endmodule // rtcctl_prescaler

/* File: core/rtcctl_sync_delay.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// models the crossing into the count domain: done after N ticks
// ----------------------------------------------------------------
module rtcctl_sync_delay import rtcctl_pkg::*; #(
    parameter int TICKS = SYNC_TICKS
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // handshake
    input  wire logic start,
    input  wire logic srcTick,
    output logic      done
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       run_r;
    logic       run_nxt;
    logic       done_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        run_nxt  = run_r;
        done_nxt = 1'b0;
        if (start) begin
            // a new request restarts the transfer
            run_nxt = 1'b1;
            cnt_nxt = '0;
        end else if (run_r && srcTick) begin
            if (cnt_r == 8'(TICKS - 1)) begin
                run_nxt  = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            done  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            done  <= done_nxt;
        end
    end
endmodule // rtcctl_sync_delay

/* File: bench/rtcctl_asserts.sv */
`timescale 1ns/10ps
// ---------------------------------------------
// port checks of the counter control block
// ---------------------------------------------
module rtcctl_asserts import rtcctl_pkg::*; #(
    parameter int SYNC_LEN = 2
) (
    // clock and reset
    input wire logic              mclk,
    input wire logic              rst,
    // register port
    input wire logic              busRead,
    input wire logic              busWrite,
    input wire logic [DATA_W-1:0] busRdata,
    input wire logic              writeGuard,
    // counter side
    input wire logic              matchHit,
    input wire logic              countEnable,
    input wire logic              countTick,
    input wire logic [1:0]        countMode,
    input wire logic              clearOnMatch,
    input wire logic              hour12Format,
    input wire logic              counterClear,
    input wire logic              debugRun
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_rdata_idle: assert property (
        !busRead |=> busRdata == READ_ZERO)
        else $error("read data left standing");
    a_tick_enabled: assert property (
        countTick |-> countEnable)
        else $error("count tick while disabled");
    a_clear_fires: assert property (
        matchHit && countEnable && clearOnMatch |=> counterClear)
        else $error("match did not clear counter");
    a_clear_cause: assert property (
        counterClear |-> $past(matchHit) && $past(clearOnMatch))
        else $error("counter clear without cause");
    a_clear_gate: assert property (
        clearOnMatch |-> countMode == 2'h0 || countMode == 2'h2)
        else $error("clear on match in wrong mode");
    a_hour_gate: assert property (
        hour12Format |-> countMode == 2'h2)
        else $error("hour format outside calendar mode");
    a_guard_debug: assert property (
        writeGuard && busWrite |-> ##2 $stable(debugRun))
        else $error("guarded write changed debug bit");
    a_mode_locked: assert property (
        countEnable && $past(countEnable) |-> $stable(countMode)
            && $stable(clearOnMatch) && $stable(hour12Format))
        else $error("locked field changed while enabled");

    c_tick: cover property (countTick);
    c_clear: cover property (counterClear);
    c_guard: cover property (writeGuard && busWrite);
    c_hour12: cover property (hour12Format);
endmodule // rtcctl_asserts

bind rtcctl_ctrl rtcctl_asserts #(.SYNC_LEN(SYNC_LEN)) rtcctl_asserts_inst (
    .mclk, .rst, .busRead, .busWrite, .busRdata, .writeGuard, .matchHit,
    .countEnable, .countTick, .countMode, .clearOnMatch, .hour12Format,
    .counterClear, .debugRun);

/* File: bench/rtcctl_ctrl_tb.sv */
`timescale 1ns/10ps
module rtcctl_ctrl_tb import rtcctl_pkg::*;;
    typedef struct {
        logic [7:0]  a;
        logic [1:0]  be;
        logic [15:0] d;
        logic [15:0] rb;
        logic [15:0] st;
    } rtcctl_row_t;

    logic        mclk = 1'b0;
    logic        rst, busWrite, busRead, writeGuard, matchHit;
    logic        srcTick = 1'b0;
    logic [7:0]  busAddr;
    logic [15:0] busWdata, busRdata, q;
    logic [1:0]  busByteEn, countMode;
    logic        countEnable, countTick, clearOnMatch, hour12Format;
    logic        counterClear, debugRun;
    int          n_fail, total_checks, cycles, tk, n;
    rtcctl_row_t rows [5] = '{
        '{CONTROL_ADDR, 2'b10, 16'h0AFF, 16'h0A00, 16'h0000},
        '{CONTROL_ADDR, 2'b01, 16'h00C8, 16'h0AC8, 16'h0080},
        '{CONTROL_ADDR, 2'b01, 16'h00C4, 16'h0AC4, 16'h0080},
        '{DEBUG_ADDR,   2'b01, 16'h0001, 16'h0001, 16'h0000},
        '{8'h20,        2'b11, 16'hFFFF, 16'h0000, 16'h0000}};

    rtcctl_ctrl #(.SYNC_LEN(2)) rtcctl_ctrl_inst (
        .mclk, .rst, .busAddr, .busWdata, .busByteEn, .busWrite, .busRead,
        .busRdata, .writeGuard, .srcTick, .matchHit, .countEnable,
        .countTick, .countMode, .clearOnMatch, .hour12Format,
        .counterClear, .debugRun);

    always #4 mclk = ~mclk;

    // source ticks every fourth cycle, unrelated to bus traffic
    always @(posedge mclk) begin
        tk <= (tk + 1) % 4;
        srcTick <= (tk == 3);
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            complete_run();
        end
    end

    // ---------------------------------------------
    // bus and check tasks
    // ---------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [1:0] b,
                      input logic [15:0] d);
        busAddr <= a;
        busByteEn <= b;
        busWdata <= d;
        busWrite <= 1'b1;
        @(posedge mclk);
        busWrite <= 1'b0;
        #1;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [1:0] b,
                      output logic [15:0] r);
        busAddr <= a;
        busByteEn <= b;
        busRead <= 1'b1;
        @(posedge mclk);
        busRead <= 1'b0;
        #1;
        r = busRdata;
    endtask

    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        rd(a, 2'b11, q);
        chk(q, e);
    endtask

    task automatic idle();
        repeat (40) begin
            rd(STATUS_ADDR, 2'b11, q);
            if (q[SYNC_PEND_BIT] == 1'b0) break;
        end
        chk(q, 16'h0000);
    endtask

    task automatic waitEn(input logic v);
        repeat (40) begin
            if (countEnable === v) break;
            @(posedge mclk);
            #1;
        end
        chk({15'h0000, countEnable}, {15'h0000, v});
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        {rst, busWrite, busRead, writeGuard, matchHit} = 5'b10000;
        {busAddr, busWdata, busByteEn} = '0;
        {n_fail, total_checks, cycles, tk} = '0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rc(CONTROL_ADDR, CONTROL_RESET);
        rc(STATUS_ADDR, 16'h0000);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].be, rows[i].d);
            rc(rows[i].a, rows[i].rb);
            rc(STATUS_ADDR, rows[i].st);
            idle();
        end
        rd(CONTROL_ADDR, 2'b10, q);
        chk(q, 16'h0A00);
        rd(CONTROL_ADDR, 2'b01, q);
        chk(q, 16'h00C4);
        chk({14'h0, countMode}, 16'h0001);
        chk({14'h0, clearOnMatch, hour12Format}, 16'h0000);
        for (int c = 0; c <= 10; c++) begin
            wr(CONTROL_ADDR, 2'b10, {4'h0, c[3:0], 8'h00});
            wr(CONTROL_ADDR, 2'b01, 16'h0002);
            rc(CONTROL_ADDR, {4'h0, c[3:0], 8'h02});
            rc(STATUS_ADDR, 16'h0080);
            idle();
            waitEn(1'b1);
            n = 0;
            repeat (16 << c) begin
                @(posedge mclk);
                #1;
                if (countTick === 1'b1) n++;
            end
            chk({15'h0000, n inside {[3:5]}}, 16'h0001);
            wr(CONTROL_ADDR, 2'b01, 16'h0000);
            idle();
            waitEn(1'b0);
        end
        // fields locked once enabled
        wr(CONTROL_ADDR, 2'b01, 16'h00C8);
        idle();
        wr(CONTROL_ADDR, 2'b01, 16'h00CA);
        idle();
        waitEn(1'b1);
        wr(CONTROL_ADDR, 2'b11, 16'h0106);
        rc(CONTROL_ADDR, 16'h0ACA);
        idle();
        chk({14'h0, clearOnMatch, hour12Format}, 16'h0003);
        chk({14'h0, countMode}, 16'h0002);
        matchHit <= 1'b1;
        @(posedge mclk);
        matchHit <= 1'b0;
        #1;
        chk({15'h0000, counterClear}, 16'h0001);
        writeGuard <= 1'b1;
        wr(CONTROL_ADDR, 2'b01, 16'h0000);
        wr(DEBUG_ADDR, 2'b01, 16'h0000);
        writeGuard <= 1'b0;
        rc(CONTROL_ADDR, 16'h0ACA);
        rc(DEBUG_ADDR, 16'h0001);
        // soft reset with other fields in the same write
        wr(CONTROL_ADDR, 2'b01, 16'h0005);
        rd(CONTROL_ADDR, 2'b11, q);
        chk(q, 16'h0AC9);
        rc(STATUS_ADDR, 16'h0080);
        idle();
        @(posedge mclk);
        rc(CONTROL_ADDR, CONTROL_RESET);
        rc(DEBUG_ADDR, 16'h0001);
        chk({15'h0000, countEnable}, 16'h0000);
        chk({15'h0000, debugRun}, 16'h0001);
        complete_run();
    end
endmodule // rtcctl_ctrl_tb
